// ==== tmon_dev_end.sv ====
// Monitor end: register bank, status flags and alert latch
// Operation
// - Separate read and write addresses, except offset and remote low limits sharing 0x11..0x14
// - Master never writes above address 0x14
// - First written byte loads the pointer
// - Value registers written only by converter
// - Offset is signed 11 bits, hi/lo
// - Offset added to each remote result
// - Offset bytes reset to zero
// - Remote value saturates on overflow
// - Value, config and rate reset values
// - Limit high bytes reset values
// - Remote low bytes reset to zero
// - One-shot write starts one conversion
// - Status bit 7 shows busy
// - Status bits 6..3 limit flags
// - Status bit 2 open sensor
// - Any flag sets alert latch
// - Status read clears only ended flags
// - Status read leaves alert latch alone
// - Alert response releases latch when clean
// - Config bit 7 masks alert
// - One-shot in standby, one cycle
// - Strict greater / strict less compares
// - Flags stay until status read
`timescale 1ns/1ps
`include "tmon_map.svh"
`default_nettype none

module tmon_dev_end #(
  parameter logic [6:0] DEV_ADDR = 7'h2a,
  parameter logic [7:0] MAKER_ID = 8'h5a, // Arbitrary value
  parameter logic [7:0] REV_ID   = 8'h07  // Arbitrary value
) (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  tmon_link_if.dev         link,
  input  wire logic        conv_done_i,
  input  wire logic [7:0]  local_raw_i,
  input  wire logic [10:0] remote_raw_i,
  input  wire logic        open_i,
  input  wire logic        busy_i,
  input  wire logic        standby_pin_n_i,
  output logic             conv_start_o,
  output logic             standby_o
);
  import tmon_pkg::*;

  // ****************************************
  // Link and standby pin synchronisers
  // ****************************************
  logic        lclk_s1, lclk_s2, lclk_s3;
  logic        valid_s1, valid_s2;
  logic [2:0]  op_s1, op_s2;
  logic [7:0]  data_s1, data_s2;
  logic        pin_s1, pin_s2;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lclk_s1  <= 1'b0;
      lclk_s2  <= 1'b0;
      lclk_s3  <= 1'b0;
      valid_s1 <= 1'b0;
      valid_s2 <= 1'b0;
      op_s1    <= 3'h0;
      op_s2    <= 3'h0;
      data_s1  <= 8'h00;
      data_s2  <= 8'h00;
      pin_s1   <= 1'b1;
      pin_s2   <= 1'b1;
    end else begin
      lclk_s1  <= link.lk_clk;
      lclk_s2  <= lclk_s1;
      lclk_s3  <= lclk_s2;
      valid_s1 <= link.lk_valid;
      valid_s2 <= valid_s1;
      op_s1    <= link.lk_op;
      op_s2    <= op_s1;
      data_s1  <= link.lk_data;
      data_s2  <= data_s1;
      pin_s1   <= standby_pin_n_i;
      pin_s2   <= pin_s1;
    end
  end

  tmon_op_t op;
  logic     exec;
  assign op   = tmon_op_t'(op_s2);
  assign exec = lclk_s2 & ~lclk_s3 & valid_s2;

  // ****************************************
  // Register state
  // ****************************************
  logic [7:0] ptr_reg, ptr_next;
  logic [7:0] local_reg, local_next, rhi_reg, rhi_next, rlo_reg, rlo_next;
  logic [7:0] cfg_reg, cfg_next, rate_reg, rate_next;
  logic [7:0] lhl_reg, lhl_next, lll_reg, lll_next;
  logic [7:0] rhl_reg, rhl_next, rll_reg, rll_next;
  logic [7:0] rhl_lo_reg, rhl_lo_next, rll_lo_reg, rll_lo_next;
  logic [7:0] ofs_hi_reg, ofs_hi_next, ofs_lo_reg, ofs_lo_next;
  logic [4:0] flags_reg, flags_next;
  logic       open_reg, open_next;
  logic       latch_reg, latch_next;
  logic [7:0] rdata_reg, rdata_next;
  logic       alert_n_reg, alert_n_next;
  logic       start_reg, start_next;
  logic       standby_pin_n_reg, standby_pin_n_next;

  // ****************************************
  // Offset addition with saturation
  // ****************************************
  logic signed [11:0] rsum;
  logic [10:0]        rsat;
  always_comb begin
    rsum = $signed({remote_raw_i[10], remote_raw_i}) +
           $signed({ofs_hi_reg[7], ofs_hi_reg, ofs_lo_reg[7:5]});
    if (rsum[11] != rsum[10]) begin
      rsat = rsum[11] ? `TM_SAT_MIN : `TM_SAT_MAX;
    end else begin
      rsat = rsum[10:0];
    end
  end

  // ****************************************
  // Limit comparisons and read decode
  // ****************************************
  logic [4:0] cond;
  logic [7:0] rd_byte;
  assign cond = {
    $signed(local_reg) > $signed(lhl_reg),
    $signed(local_reg) < $signed(lll_reg),
    $signed({rhi_reg, rlo_reg[7:5]}) > $signed({rhl_reg, rhl_lo_reg[7:5]}),
    $signed({rhi_reg, rlo_reg[7:5]}) < $signed({rll_reg, rll_lo_reg[7:5]}),
    open_reg
  };

  always_comb begin
    case (ptr_reg)
      `TM_RD_LOCAL:   rd_byte = local_reg;
      `TM_RD_RVAL_HI: rd_byte = rhi_reg;
      `TM_RD_STATUS:  rd_byte = {busy_i, flags_reg, 2'b00};
      `TM_RD_CFG:     rd_byte = cfg_reg;
      `TM_RD_RATE:    rd_byte = rate_reg;
      `TM_RD_LHL:     rd_byte = lhl_reg;
      `TM_RD_LLL:     rd_byte = lll_reg;
      `TM_RD_RHL_HI:  rd_byte = rhl_reg;
      `TM_RD_RLL_HI:  rd_byte = rll_reg;
      `TM_RD_RVAL_LO: rd_byte = rlo_reg;
      `TM_RW_OFS_HI:  rd_byte = ofs_hi_reg;
      `TM_RW_OFS_LO:  rd_byte = ofs_lo_reg;
      `TM_RW_RHL_LO:  rd_byte = rhl_lo_reg;
      `TM_RW_RLL_LO:  rd_byte = rll_lo_reg;
      `TM_RD_MAKER:   rd_byte = MAKER_ID;
      `TM_RD_REV:     rd_byte = REV_ID;
      default:        rd_byte = 8'h00;
    endcase
  end

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    ptr_next     = ptr_reg;
    local_next   = local_reg;
    rhi_next     = rhi_reg;
    rlo_next     = rlo_reg;
    cfg_next     = cfg_reg;
    rate_next    = rate_reg;
    lhl_next     = lhl_reg;
    lll_next     = lll_reg;
    rhl_next     = rhl_reg;
    rll_next     = rll_reg;
    rhl_lo_next  = rhl_lo_reg;
    rll_lo_next  = rll_lo_reg;
    ofs_hi_next  = ofs_hi_reg;
    ofs_lo_next  = ofs_lo_reg;
    open_next    = open_reg;
    rdata_next   = rdata_reg;
    start_next   = 1'b0;
    flags_next   = flags_reg | cond;
    latch_next   = latch_reg | (|flags_reg);

    if (conv_done_i) begin
      local_next = local_raw_i;
      rhi_next   = rsat[10:3];
      rlo_next   = {rsat[2:0], 5'h00};
      open_next  = open_i;
    end

    if (exec) begin
      unique case (op)
        TMON_OP_PTR:  ptr_next = data_s2;
        TMON_OP_DATA: begin
          case (ptr_reg)
            `TM_WR_CFG:     cfg_next    = data_s2;
            `TM_WR_RATE:    rate_next   = data_s2;
            `TM_WR_LHL:     lhl_next    = data_s2;
            `TM_WR_LLL:     lll_next    = data_s2;
            `TM_WR_RHL_HI:  rhl_next    = data_s2;
            `TM_WR_RLL_HI:  rll_next    = data_s2;
            `TM_WR_ONESHOT: start_next  = 1'b1;
            `TM_RW_OFS_HI:  ofs_hi_next = data_s2;
            `TM_RW_OFS_LO:  ofs_lo_next = {data_s2[7:5], 5'h00};
            `TM_RW_RHL_LO:  rhl_lo_next = {data_s2[7:5], 5'h00};
            `TM_RW_RLL_LO:  rll_lo_next = {data_s2[7:5], 5'h00};
            default:        ;
          endcase
        end
        TMON_OP_READ: begin
          rdata_next = rd_byte;
          if (ptr_reg == `TM_RD_STATUS) begin
            flags_next = cond;
          end
        end
        TMON_OP_ARA: begin
          rdata_next = {DEV_ADDR, 1'b0};
          if (flags_reg == 5'h00 && cond == 5'h00) begin
            latch_next = 1'b0;
          end
        end
        TMON_OP_NONE: ;
        default:      ;
      endcase
    end

    alert_n_next = ~(latch_next & ~cfg_next[`TM_CFG_MASK]);
    standby_pin_n_next    = cfg_next[`TM_CFG_STANDBY_PIN_N] | ~pin_s2;
  end

  // ****************************************
  // State registers
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ptr_reg     <= `TM_RST_ZERO;
      local_reg   <= `TM_RST_VALUE;
      rhi_reg     <= `TM_RST_VALUE;
      rlo_reg     <= `TM_RST_ZERO;
      cfg_reg     <= `TM_RST_CFG;
      rate_reg    <= `TM_RST_RATE;
      lhl_reg     <= `TM_RST_HIGH;
      lll_reg     <= `TM_RST_LOW;
      rhl_reg     <= `TM_RST_HIGH;
      rll_reg     <= `TM_RST_LOW;
      rhl_lo_reg  <= `TM_RST_ZERO;
      rll_lo_reg  <= `TM_RST_ZERO;
      ofs_hi_reg  <= `TM_RST_ZERO;
      ofs_lo_reg  <= `TM_RST_ZERO;
      flags_reg   <= 5'h00;
      open_reg    <= 1'b0;
      latch_reg   <= 1'b0;
      rdata_reg   <= 8'h00;
      alert_n_reg <= 1'b1;
      start_reg   <= 1'b0;
      standby_pin_n_reg    <= 1'b0;
    end else begin
      ptr_reg     <= ptr_next;
      local_reg   <= local_next;
      rhi_reg     <= rhi_next;
      rlo_reg     <= rlo_next;
      cfg_reg     <= cfg_next;
      rate_reg    <= rate_next;
      lhl_reg     <= lhl_next;
      lll_reg     <= lll_next;
      rhl_reg     <= rhl_next;
      rll_reg     <= rll_next;
      rhl_lo_reg  <= rhl_lo_next;
      rll_lo_reg  <= rll_lo_next;
      ofs_hi_reg  <= ofs_hi_next;
      ofs_lo_reg  <= ofs_lo_next;
      flags_reg   <= flags_next;
      open_reg    <= open_next;
      latch_reg   <= latch_next;
      rdata_reg   <= rdata_next;
      alert_n_reg <= alert_n_next;
      start_reg   <= start_next;
      standby_pin_n_reg    <= standby_pin_n_next;
    end
  end

  assign link.lk_rdata = rdata_reg;
  assign link.alert_n  = alert_n_reg;
  assign conv_start_o  = start_reg;
  assign standby_o     = standby_pin_n_reg;

endmodule

`default_nettype wire

// ==== tmon_map.svh ====
// Register map, field positions, reset values and timing counts of the temperature monitor
`ifndef TMON_MAP_SVH
`define TMON_MAP_SVH

// ****************************************
// Read addresses
// ****************************************
`define TM_RD_LOCAL      8'h00
`define TM_RD_RVAL_HI    8'h01
`define TM_RD_STATUS     8'h02
`define TM_RD_CFG        8'h03
`define TM_RD_RATE       8'h04
`define TM_RD_LHL        8'h05
`define TM_RD_LLL        8'h06
`define TM_RD_RHL_HI     8'h07
`define TM_RD_RLL_HI     8'h08
`define TM_RD_RVAL_LO    8'h10
`define TM_RD_RSVD_A     8'h19
`define TM_RD_RSVD_B     8'h20
`define TM_RD_MAKER      8'hfe
`define TM_RD_REV        8'hff

// ****************************************
// Write addresses
// ****************************************
`define TM_WR_CFG        8'h09
`define TM_WR_RATE       8'h0a
`define TM_WR_LHL        8'h0b
`define TM_WR_LLL        8'h0c
`define TM_WR_RHL_HI     8'h0d
`define TM_WR_RLL_HI     8'h0e
`define TM_WR_ONESHOT    8'h0f
`define TM_WR_LAST       8'h14

// ****************************************
// Shared read and write addresses
// ****************************************
`define TM_RW_OFS_HI     8'h11
`define TM_RW_OFS_LO     8'h12
`define TM_RW_RHL_LO     8'h13
`define TM_RW_RLL_LO     8'h14

// ****************************************
// Reset values
// ****************************************
`define TM_RST_VALUE     8'h80
`define TM_RST_CFG       8'h00
`define TM_RST_RATE      8'h02
`define TM_RST_HIGH      8'h7f
`define TM_RST_LOW       8'hc9
`define TM_RST_ZERO      8'h00

// ****************************************
// Field positions
// ****************************************
`define TM_ST_BUSY       7
`define TM_ST_FLAG_HI    6
`define TM_ST_FLAG_LO    2
`define TM_CFG_MASK      7
`define TM_CFG_STANDBY_PIN_N      6

// ****************************************
// Remote value saturation limits, 8.3 format
// ****************************************
`define TM_SAT_MAX       11'h3ff
`define TM_SAT_MIN       11'h400

// ****************************************
// Link timing: half link period in host clocks
// ****************************************
`define TM_LINK_HALF     8

`endif

// ==== tmon_pkg.sv ====
// Types shared by both ends of the temperature monitor link
`default_nettype none

package tmon_pkg;

  typedef enum logic [2:0] {
    TMON_OP_NONE,
    TMON_OP_PTR,
    TMON_OP_DATA,
    TMON_OP_READ,
    TMON_OP_ARA
  } tmon_op_t;

  typedef enum logic [1:0] {
    TMON_CMD_WRITE,
    TMON_CMD_READ,
    TMON_CMD_PTR,
    TMON_CMD_ARA
  } tmon_cmd_t;

endpackage

`default_nettype wire

// ==== tmon_link_if.sv ====
// Link between the host end and the monitor end
`timescale 1ns/1ps
`default_nettype none

interface tmon_link_if;
  import tmon_pkg::*;

  logic           lk_clk;
  logic           lk_valid;
  tmon_op_t       lk_op;
  logic [7:0]     lk_data;
  logic [7:0]     lk_rdata;
  logic           alert_n;

  modport dev  (input lk_clk, lk_valid, lk_op, lk_data, output lk_rdata, alert_n);
  modport host (output lk_clk, lk_valid, lk_op, lk_data, input lk_rdata, alert_n);
endinterface

`default_nettype wire

// ==== tmon_host_end.sv ====
// Host end: turns register commands into link bytes and returns read data
`timescale 1ns/1ps
`include "tmon_map.svh"
`default_nettype none

module tmon_host_end #(
  parameter int LINK_HALF = `TM_LINK_HALF
) (
  input  wire logic                clk_i,
  input  wire logic                rst_b_i,
  tmon_link_if.host                link,
  input  wire logic                cmd_valid_i,
  input  wire tmon_pkg::tmon_cmd_t cmd_kind_i,
  input  wire logic [7:0]          cmd_addr_i,
  input  wire logic [7:0]          cmd_data_i,
  output logic                     cmd_ready_o,
  output logic                     rsp_valid_o,
  output logic [7:0]               rsp_data_o,
  output logic                     alert_o
);
  import tmon_pkg::*;

  if (LINK_HALF < 6 || LINK_HALF > 127) begin : g_chk
    $error("LINK_HALF out of range");
  end

  localparam logic [7:0] HALF = 8'(LINK_HALF);
  localparam logic [7:0] LAST = 8'(2 * LINK_HALF - 1);

  typedef enum {TMON_H_IDLE, TMON_H_LOAD, TMON_H_SECOND, TMON_H_FINISH} tmon_hstate_t;

  // ****************************************
  // Returning signal synchronisers
  // ****************************************
  logic [7:0] rd_s1, rd_s2;
  logic       al_s1, al_s2;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_s1 <= 8'h00;
      rd_s2 <= 8'h00;
      al_s1 <= 1'b1;
      al_s2 <= 1'b1;
    end else begin
      rd_s1 <= link.lk_rdata;
      rd_s2 <= rd_s1;
      al_s1 <= link.alert_n;
      al_s2 <= al_s1;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  tmon_hstate_t st_reg, st_next;
  tmon_cmd_t    kind_reg, kind_next;
  tmon_op_t     op_reg, op_next;
  logic [7:0]   phase_reg, phase_next, addr_reg, addr_next, data_reg, data_next;
  logic [7:0]   ldata_reg, ldata_next, rsp_reg, rsp_next;
  logic         lclk_reg, lclk_next, valid_reg, valid_next;
  logic         ready_reg, ready_next, rspv_reg, rspv_next, alert_reg;
  logic         tick;

  always_comb begin
    tick       = (phase_reg == LAST);
    phase_next = tick ? 8'h00 : phase_reg + 8'h01;
    lclk_next  = (phase_next >= HALF);
    st_next    = st_reg;
    kind_next  = kind_reg;
    addr_next  = addr_reg;
    data_next  = data_reg;
    op_next    = op_reg;
    ldata_next = ldata_reg;
    valid_next = valid_reg;
    ready_next = ready_reg;
    rsp_next   = rsp_reg;
    rspv_next  = 1'b0;
    unique case (st_reg)
      TMON_H_IDLE: begin
        if (cmd_valid_i && ready_reg) begin
          kind_next  = cmd_kind_i;
          addr_next  = cmd_addr_i;
          data_next  = cmd_data_i;
          ready_next = 1'b0;
          st_next    = TMON_H_LOAD;
        end
      end
      TMON_H_LOAD: begin
        if (tick) begin
          valid_next = 1'b1;
          op_next    = (kind_reg == TMON_CMD_ARA) ? TMON_OP_ARA : TMON_OP_PTR;
          ldata_next = addr_reg;
          st_next    = (kind_reg == TMON_CMD_WRITE || kind_reg == TMON_CMD_READ) ? TMON_H_SECOND : TMON_H_FINISH;
        end
      end
      TMON_H_SECOND: begin
        if (tick) begin
          op_next    = (kind_reg == TMON_CMD_WRITE) ? TMON_OP_DATA : TMON_OP_READ;
          ldata_next = data_reg;
          st_next    = TMON_H_FINISH;
        end
      end
      TMON_H_FINISH: begin
        if (tick) begin
          valid_next = 1'b0;
          op_next    = TMON_OP_NONE;
          rsp_next   = (op_reg == TMON_OP_READ || op_reg == TMON_OP_ARA) ? rd_s2 : 8'h00;
          rspv_next  = 1'b1;
          ready_next = 1'b1;
          st_next    = TMON_H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg    <= TMON_H_IDLE;
      kind_reg  <= TMON_CMD_WRITE;
      op_reg    <= TMON_OP_NONE;
      phase_reg <= 8'h00;
      addr_reg  <= 8'h00;
      data_reg  <= 8'h00;
      ldata_reg <= 8'h00;
      rsp_reg   <= 8'h00;
      lclk_reg  <= 1'b0;
      valid_reg <= 1'b0;
      ready_reg <= 1'b1;
      rspv_reg  <= 1'b0;
      alert_reg <= 1'b0;
    end else begin
      st_reg    <= st_next;
      kind_reg  <= kind_next;
      op_reg    <= op_next;
      phase_reg <= phase_next;
      addr_reg  <= addr_next;
      data_reg  <= data_next;
      ldata_reg <= ldata_next;
      rsp_reg   <= rsp_next;
      lclk_reg  <= lclk_next;
      valid_reg <= valid_next;
      ready_reg <= ready_next;
      rspv_reg  <= rspv_next;
      alert_reg <= ~al_s2;
    end
  end

  assign link.lk_clk   = lclk_reg;
  assign link.lk_valid = valid_reg;
  assign link.lk_op    = op_reg;
  assign link.lk_data  = ldata_reg;
  assign cmd_ready_o   = ready_reg;
  assign rsp_valid_o   = rspv_reg;
  assign rsp_data_o    = rsp_reg;
  assign alert_o       = alert_reg;

endmodule

`default_nettype wire

// ==== tmon_link_sva.sv ====
// Link checker placed beside the host and monitor ends
`timescale 1ns/1ps
`default_nettype none

module tmon_link_sva #(
  parameter logic [6:0] DEV_ADDR = 7'h2a
) (
  input wire logic               clk_i,
  input wire logic               rst_b_i,
  input wire logic               lk_clk,
  input wire logic               lk_valid,
  input wire tmon_pkg::tmon_op_t lk_op,
  input wire logic [7:0]         lk_data,
  input wire logic [7:0]         lk_rdata,
  input wire logic               alert_n
);
  import tmon_pkg::*;
  // **********************************
  // Link checks
  // **********************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_ptr_start;
    $rose(lk_valid) && lk_op == TMON_OP_PTR;
  endsequence
  sequence s_ara_edge;
    $rose(lk_clk) && lk_valid && lk_op == TMON_OP_ARA;
  endsequence
  property p_half_period;
    $rose(lk_clk) |-> ##8 $fell(lk_clk);
  endproperty
  property p_op_at_fall;
    $changed(lk_op) |-> $fell(lk_clk);
  endproperty
  property p_start_at_fall;
    $rose(lk_valid) |-> $fell(lk_clk);
  endproperty
  property p_data_steady;
    lk_clk |-> $stable(lk_data);
  endproperty
  property p_valid_op;
    lk_valid == (lk_op != TMON_OP_NONE);
  endproperty
  property p_ptr_then;
    s_ptr_start |-> ##16 (lk_op != TMON_OP_PTR && lk_op != TMON_OP_ARA);
  endproperty
  property p_rdata_cause;
    $changed(lk_rdata) |-> lk_valid && lk_op inside {TMON_OP_READ, TMON_OP_ARA};
  endproperty
  property p_ara_addr;
    s_ara_edge |-> ##[2:8] (lk_rdata == {DEV_ADDR, 1'b0});
  endproperty
  property p_alert_release;
    $rose(alert_n) |-> lk_valid && lk_op inside {TMON_OP_ARA, TMON_OP_DATA};
  endproperty

  a_half_period: assert property (p_half_period)
    else $error("link clock high time wrong");
  a_op_at_fall: assert property (p_op_at_fall)
    else $error("link op changed off the falling edge");
  a_start_at_fall: assert property (p_start_at_fall)
    else $error("link byte started off the falling edge");
  a_data_steady: assert property (p_data_steady)
    else $error("link data moved while clock high");
  a_valid_op: assert property (p_valid_op)
    else $error("link valid and op disagree");
  a_ptr_then: assert property (p_ptr_then)
    else $error("pointer byte not followed by data or read");
  a_rdata_cause: assert property (p_rdata_cause)
    else $error("read data moved without a read");
  a_ara_addr: assert property (p_ara_addr)
    else $error("alert response address wrong");
  a_alert_release: assert property (p_alert_release)
    else $error("alert released without response or config write");
endmodule

`default_nettype wire

// ==== temp_monitor_register_bank_tb.sv ====
// Testbench joining host end and monitor end over the link
`timescale 1ns/1ps
`include "tmon_map.svh"
`default_nettype none

module temp_monitor_register_bank_tb;
  import tmon_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        cmd_valid_i = 1'b0;
  tmon_cmd_t   cmd_kind_i = TMON_CMD_READ;
  logic [7:0]  cmd_addr_i = 8'h00;
  logic [7:0]  cmd_data_i = 8'h00;
  logic        conv_done_i = 1'b0;
  logic [7:0]  local_raw_i = 8'h00;
  logic [10:0] remote_raw_i = 11'h000;
  logic        open_i = 1'b0;
  logic        busy_i = 1'b0;
  logic        standby_pin_n_i = 1'b1;
  logic        cmd_ready_o;
  logic        rsp_valid_o;
  logic [7:0]  rsp_data_o;
  logic        alert_o;
  logic        conv_start_o;
  logic        standby_o;
  logic [7:0]  rd;
  int          bad_count = 0;
  int          compares = 0;
  int          starts = 0;

  tmon_link_if link_if();
  tmon_host_end #(.LINK_HALF(8)) tmon_host_end_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .link(link_if),
    .cmd_valid_i(cmd_valid_i), .cmd_kind_i(cmd_kind_i), .cmd_addr_i(cmd_addr_i), .cmd_data_i(cmd_data_i),
    .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .alert_o(alert_o));
  tmon_dev_end tmon_dev_end_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .link(link_if),
    .conv_done_i(conv_done_i), .local_raw_i(local_raw_i), .remote_raw_i(remote_raw_i), .open_i(open_i),
    .busy_i(busy_i), .standby_pin_n_i(standby_pin_n_i), .conv_start_o(conv_start_o), .standby_o(standby_o));
  tmon_link_sva tmon_link_sva_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .lk_clk(link_if.lk_clk),
    .lk_valid(link_if.lk_valid), .lk_op(link_if.lk_op), .lk_data(link_if.lk_data),
    .lk_rdata(link_if.lk_rdata), .alert_n(link_if.alert_n));

  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (conv_start_o === 1'b1) begin
      starts++;
    end
  end

  // **********************************
  // Shared tasks
  // **********************************
  task automatic close_out();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask

  task automatic cmd(input tmon_cmd_t k, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    #1;
    cmd_valid_i = 1'b1;
    cmd_kind_i = k;
    cmd_addr_i = a;
    cmd_data_i = d;
    @(posedge clk_i);
    #1;
    cmd_valid_i = 1'b0;
    chk("ready low", 8'h00, {7'h00, cmd_ready_o});
    for (n = 0; n < 200 && rsp_valid_o !== 1'b1; n++) begin
      @(posedge clk_i);
      #1;
    end
    rd = rsp_data_o;
    if (n == 200) begin
      bad_count++;
      close_out();
    end
    chk("ready high", 8'h01, {7'h00, cmd_ready_o});
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cmd(TMON_CMD_WRITE, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string what);
    cmd(TMON_CMD_READ, a, 8'h00);
    chk(what, exp, rd);
  endtask

  task automatic conv(input logic [7:0] l, input logic [10:0] r, input logic o);
    @(posedge clk_i);
    #1;
    local_raw_i = l;
    remote_raw_i = r;
    open_i = o;
    conv_done_i = 1'b1;
    @(posedge clk_i);
    #1;
    conv_done_i = 1'b0;
  endtask

  task automatic alert_is(input logic exp);
    int n;
    for (n = 0; n < 30 && alert_o !== exp; n++) begin
      @(posedge clk_i);
      #1;
    end
    chk("alert", {7'h00, exp}, {7'h00, alert_o});
  endtask

  task automatic ara(input logic exp);
    cmd(TMON_CMD_ARA, 8'h00, 8'h00);
    chk("ara byte", 8'h54, rd);
    alert_is(exp);
  endtask

  // **********************************
  // Scenarios
  // **********************************
  task automatic t_resets();
    logic [7:0] adr [14] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
                             8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h19};
    logic [7:0] exp [14] = '{8'h80, 8'h80, 8'h00, 8'h02, 8'h7f, 8'hc9, 8'h7f, 8'hc9,
                             8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 14; i++) begin
      rdc(adr[i], exp[i], "reset value");
    end
  endtask

  task automatic t_access();
    wr(`TM_WR_RATE, 8'h05);
    rdc(`TM_RD_RATE, 8'h05, "rate");
    cmd(TMON_CMD_PTR, `TM_RD_CFG, 8'h00);
    chk("ptr rsp", 8'h00, rd);
    wr(`TM_RD_LHL, 8'h11);
    rdc(`TM_RD_LHL, `TM_RST_HIGH, "limit kept");
    wr(`TM_RD_LOCAL, 8'h11);
    rdc(`TM_RD_LOCAL, `TM_RST_VALUE, "value kept");
    wr(`TM_RW_RHL_LO, 8'hff);
    rdc(`TM_RW_RHL_LO, 8'he0, "low byte");
    wr(`TM_RW_RHL_LO, 8'h00);
  endtask

  task automatic t_offset();
    conv(8'h19, 11'h090, 1'b0);
    rdc(`TM_RD_RVAL_HI, 8'h12, "no offset hi");
    rdc(`TM_RD_LOCAL, 8'h19, "local value");
    wr(`TM_RW_OFS_HI, 8'hff);
    wr(`TM_RW_OFS_LO, 8'he0);
    conv(8'h19, 11'h090, 1'b0);
    rdc(`TM_RD_RVAL_HI, 8'h11, "offset hi");
    rdc(`TM_RD_RVAL_LO, 8'he0, "offset lo");
    wr(`TM_RW_OFS_HI, 8'h7f);
    conv(8'h19, 11'h090, 1'b0);
    rdc(`TM_RD_RVAL_HI, 8'h7f, "sat max hi");
    rdc(`TM_RD_RVAL_LO, 8'he0, "sat max lo");
    wr(`TM_RW_OFS_HI, 8'h80);
    wr(`TM_RW_OFS_LO, 8'h00);
    conv(8'h19, 11'h7ff, 1'b0);
    rdc(`TM_RD_RVAL_HI, 8'h80, "sat min hi");
    rdc(`TM_RD_RVAL_LO, 8'h00, "sat min lo");
    wr(`TM_RW_OFS_HI, 8'h00);
  endtask

  task automatic t_flags();
    rdc(`TM_RD_STATUS, 8'h38, "flags on");
    alert_is(1'b1);
    ara(1'b1);
    conv(8'h19, 11'h090, 1'b0);
    rdc(`TM_RD_STATUS, 8'h08, "flags held");
    rdc(`TM_RD_STATUS, 8'h00, "flags gone");
    alert_is(1'b1);
    ara(1'b0);
    wr(`TM_WR_LHL, 8'h19);
    wr(`TM_WR_RHL_HI, 8'h12);
    conv(8'h19, 11'h090, 1'b0);
    rdc(`TM_RD_STATUS, 8'h00, "equal no trip");
    busy_i = 1'b1;
    conv(8'h1a, 11'h091, 1'b1);
    rdc(`TM_RD_STATUS, 8'hd4, "high and open");
    busy_i = 1'b0;
    wr(`TM_WR_LLL, 8'h19);
    wr(`TM_WR_RLL_HI, 8'h12);
    conv(8'h18, 11'h08f, 1'b0);
    rdc(`TM_RD_STATUS, 8'h7c, "all flags");
    rdc(`TM_RD_STATUS, 8'h28, "low persist");
    wr(`TM_WR_LLL, 8'hc9);
    wr(`TM_WR_RLL_HI, 8'hc9);
    conv(8'h19, 11'h090, 1'b0);
    rdc(`TM_RD_STATUS, 8'h28, "low latched");
    rdc(`TM_RD_STATUS, 8'h00, "clean");
    ara(1'b0);
  endtask

  task automatic t_oneshot_mask();
    wr(`TM_WR_CFG, 8'h40);
    chk("standby", 8'h01, {7'h00, standby_o});
    starts = 0;
    wr(`TM_WR_ONESHOT, 8'ha5);
    chk("starts", 8'h01, starts[7:0]);
    rdc(`TM_RD_CFG, 8'h40, "still standby");
    wr(`TM_WR_CFG, 8'h80);
    standby_pin_n_i = 1'b0;
    conv(8'h1a, 11'h090, 1'b0);
    repeat (8) @(posedge clk_i);
    #1;
    chk("masked", 8'h00, {7'h00, alert_o});
    chk("pin standby", 8'h01, {7'h00, standby_o});
    wr(`TM_WR_CFG, 8'h00);
    alert_is(1'b1);
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    #1;
    rst_b_i = 1'b1;
    t_resets();
    t_access();
    t_offset();
    t_flags();
    t_oneshot_mask();
    close_out();
  end
endmodule

`default_nettype wire
